/* src/rcr_defines.svh */
`ifndef RCR_DEFINES_SVH
`define RCR_DEFINES_SVH

// ============================================================
// register addresses on the host port
`define RCR_ADDR_W 6
`define RCR_ADDR_CTRL1 6'h05
`define RCR_ADDR_CTRL2 6'h06
`define RCR_ADDR_ANALOG_MUX_CHANNEL 6'h07

// ============================================================
// data word layout: word bit n is frame bit n+8
`define RCR_DATA_W 16
`define RCR_NUM_RAILS 7
`define RCR_NUM_TSD 6
`define RCR_C1_PD_DIS 15
`define RCR_C1_OFF_HI 14
`define RCR_C1_OFF_LO 8
`define RCR_C1_ON_HI 6
`define RCR_C1_ON_LO 0
`define RCR_C2_SLEW_HI 15
`define RCR_C2_SLEW_LO 14
`define RCR_C2_REACT_HI 13
`define RCR_C2_REACT_LO 8
`define RCR_C2_LS_HI 4
`define RCR_C2_LS_LO 3
`define RCR_C2_HS_HI 1
`define RCR_C2_HS_LO 0
`define RCR_MX_RATIO 5
`define RCR_MX_CH_HI 4
`define RCR_MX_CH_LO 0

// ============================================================
// reset values
`define RCR_LS_RESET 2'h3
`define RCR_ZERO16 16'h0000
`endif

/* src/rcr_pkg.sv */
package rcr_pkg;
    // host request on the register port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [15:0] wdata;
    } rcr_req_t;

    // nonvolatile power-up configuration
    typedef struct packed {
        logic [6:0] rail_en;
        logic [1:0] boost_slew;
        logic [5:0] thermal_reaction;
        logic [1:0] hs_drive;
    } rcr_otp_t;

    // analog settings leaving the block
    typedef struct packed {
        logic [1:0] boost_slew_sel;
        logic [1:0] prereg_lowside_drive;
        logic [1:0] prereg_highside_drive;
        logic analog_mux_channel_ratio;
        logic [4:0] analog_mux_channel;
    } rcr_analog_t;

    // load sequencer states
    typedef enum logic [1:0] {
        RCR_ST_RESET = 2'b00,
        RCR_ST_LOAD = 2'b01,
        RCR_ST_RUN = 2'b10
    } rcr_state_t;
endpackage

/* src/rcr_sync2.sv */
module rcr_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // data
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync_q
);
    logic [W-1:0] meta_q;

    // two stage synchroniser, first stage feeds only the second
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_q <= '0;
            o_sync_q <= '0;
        end
        else
        begin
            meta_q <= i_async;
            o_sync_q <= meta_q;
        end
    end
endmodule // rcr_sync2

/* src/rcr_rail_state.sv */
module rcr_rail_state (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // controls
    input wire logic i_load,
    input wire logic i_load_val,
    input wire logic i_on_req,
    input wire logic i_off_req,
    input wire logic i_tsd_evt,
    // state
    output logic o_on_q
);
    logic on_d;

    // power-up load first, then thermal trip, then off, then on; zero writes hold
    always_comb
    begin
        on_d = o_on_q;
        if (i_load)
            on_d = i_load_val;
        else if (i_tsd_evt)
            on_d = 1'b0;
        else if (i_off_req)
            on_d = 1'b0;
        else if (i_on_req)
            on_d = 1'b1;
    end

    // rail on flag
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            o_on_q <= 1'b0;
        else
            o_on_q <= on_d;
    end
endmodule // rcr_rail_state

/* src/rcr_regulator_ctrl.sv */
`include "rcr_defines.svh"

module rcr_regulator_ctrl
    import rcr_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // register port
    input wire rcr_req_t i_req,
    output logic [15:0] o_rdata_q,
    output logic o_rd_valid_q,
    output logic o_addr_err_q,
    // power-up configuration
    input wire rcr_otp_t i_otp,
    // thermal shutdown pins, boost down to ldo_b
    input wire logic [5:0] i_thermal_shutdown,
    // regulator controls
    output logic [6:0] o_rail_en_q,
    output logic o_prereg_pd_dis_q,
    output logic o_deep_failsafe_state_req_q,
    output logic o_ready_q,
    output rcr_analog_t o_analog_q
);

    // ============================================================
    // declarations
    rcr_state_t state_q;
    rcr_state_t state_d;
    logic load;
    logic running;
    logic [5:0] tsd_sync;
    logic [5:0] tsd_prev_q;
    logic [5:0] tsd_prev_d;
    logic [5:0] tsd_evt;
    logic [6:0] rail_tsd;
    logic [6:0] on_req;
    logic [6:0] off_req;
    logic [6:0] rail_on;
    logic wr_c1;
    logic wr_c2;
    logic wr_mx;
    logic hit;
    logic pd_dis_q;
    logic pd_dis_d;
    logic [1:0] slew_q;
    logic [1:0] slew_d;
    logic [5:0] react_q;
    logic [5:0] react_d;
    logic [1:0] ls_q;
    logic [1:0] ls_d;
    logic [1:0] hs_q;
    logic [1:0] hs_d;
    logic ratio_q;
    logic ratio_d;
    logic [4:0] chan_q;
    logic [4:0] chan_d;
    logic [15:0] rdata_d;
    logic rd_valid_d;
    logic addr_err_d;
    logic deep_failsafe_state_d;
    rcr_analog_t analog_d;

    // ============================================================
    // power-up load sequencer
    always_comb
    begin
        case (state_q)
            RCR_ST_RESET:
                state_d = RCR_ST_LOAD;
            RCR_ST_LOAD:
                state_d = RCR_ST_RUN;
            RCR_ST_RUN:
                state_d = RCR_ST_RUN;
            default:
                state_d = RCR_ST_RESET;
        endcase
    end

    // otp values are taken on the second edge after reset release
    assign load = (state_q == RCR_ST_LOAD);
    assign running = (state_q == RCR_ST_RUN);

    // sequencer state
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            state_q <= RCR_ST_RESET;
        else
            state_q <= state_d;
    end

    // ============================================================
    // thermal shutdown inputs
    rcr_sync2 #(
        .W(`RCR_NUM_TSD)
    ) u_tsd_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_async(i_thermal_shutdown),
        .o_sync_q(tsd_sync)
    );

    // rising edge of a synchronised shutdown flag is one event
    assign tsd_prev_d = tsd_sync;
    assign tsd_evt = tsd_sync & ~tsd_prev_q;
    assign rail_tsd = {1'b0, tsd_evt}; // pre-regulator has no reaction bit

    // edge detector history
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            tsd_prev_q <= '0;
        else
            tsd_prev_q <= tsd_prev_d;
    end

    // ============================================================
    // address decode
    always_comb
    begin
        wr_c1 = i_req.wr && running && (i_req.addr == `RCR_ADDR_CTRL1);
        wr_c2 = i_req.wr && running && (i_req.addr == `RCR_ADDR_CTRL2);
        wr_mx = i_req.wr && running && (i_req.addr == `RCR_ADDR_ANALOG_MUX_CHANNEL);
        hit = (i_req.addr == `RCR_ADDR_CTRL1) || (i_req.addr == `RCR_ADDR_CTRL2)
            || (i_req.addr == `RCR_ADDR_ANALOG_MUX_CHANNEL);
    end

    // ============================================================
    // on and off requests, one-cycle strobes from a write
    always_comb
    begin
        off_req = '0;
        on_req = '0;
        if (wr_c1)
        begin
            off_req = i_req.wdata[`RCR_C1_OFF_HI:`RCR_C1_OFF_LO];
            on_req = i_req.wdata[`RCR_C1_ON_HI:`RCR_C1_ON_LO];
        end
    end

    // one state keeper per rail: bit 6 pre-regulator down to bit 0 ldo_b
    genvar g;
    generate
        for (g = 0; g < `RCR_NUM_RAILS; g++)
        begin : g_rail
            rcr_rail_state u_rail (
                .i_sys_clk(i_sys_clk),
                .i_rst(i_rst),
                .i_load(load),
                .i_load_val(i_otp.rail_en[g]),
                .i_on_req(on_req[g]),
                .i_off_req(off_req[g]),
                .i_tsd_evt(rail_tsd[g]),
                .o_on_q(rail_on[g])
            );
        end
    endgenerate

    // ============================================================
    // deep failsafe request on a trip with reaction set
    assign deep_failsafe_state_d = |(tsd_evt & react_q);

    // ============================================================
    // configuration registers next values
    always_comb
    begin
        pd_dis_d = pd_dis_q;
        slew_d = slew_q;
        react_d = react_q;
        ls_d = ls_q;
        hs_d = hs_q;
        ratio_d = ratio_q;
        chan_d = chan_q;
        if (load)
        begin
            slew_d = i_otp.boost_slew;
            react_d = i_otp.thermal_reaction;
            hs_d = i_otp.hs_drive;
        end
        if (wr_c1)
            pd_dis_d = i_req.wdata[`RCR_C1_PD_DIS];
        if (wr_c2)
        begin
            slew_d = i_req.wdata[`RCR_C2_SLEW_HI:`RCR_C2_SLEW_LO];
            react_d = i_req.wdata[`RCR_C2_REACT_HI:`RCR_C2_REACT_LO];
            ls_d = i_req.wdata[`RCR_C2_LS_HI:`RCR_C2_LS_LO];
            hs_d = i_req.wdata[`RCR_C2_HS_HI:`RCR_C2_HS_LO];
        end
        if (wr_mx)
        begin
            ratio_d = i_req.wdata[`RCR_MX_RATIO];
            chan_d = i_req.wdata[`RCR_MX_CH_HI:`RCR_MX_CH_LO];
        end
    end

    // configuration registers, fixed reset values
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pd_dis_q <= 1'b0;
            slew_q <= '0;
            react_q <= '0;
            ls_q <= `RCR_LS_RESET;
            hs_q <= '0;
            ratio_q <= 1'b0;
            chan_q <= '0;
        end
        else
        begin
            pd_dis_q <= pd_dis_d;
            slew_q <= slew_d;
            react_q <= react_d;
            ls_q <= ls_d;
            hs_q <= hs_d;
            ratio_q <= ratio_d;
            chan_q <= chan_d;
        end
    end

    // ============================================================
    // read path; request bits of the first register read as zero
    always_comb
    begin
        rdata_d = `RCR_ZERO16;
        rd_valid_d = i_req.rd;
        addr_err_d = (i_req.rd || i_req.wr) && !hit;
        if (i_req.rd)
        begin
            case (i_req.addr)
                `RCR_ADDR_CTRL1:
                    rdata_d[`RCR_C1_PD_DIS] = pd_dis_q;
                `RCR_ADDR_CTRL2:
                begin
                    rdata_d[`RCR_C2_SLEW_HI:`RCR_C2_SLEW_LO] = slew_q;
                    rdata_d[`RCR_C2_REACT_HI:`RCR_C2_REACT_LO] = react_q;
                    rdata_d[`RCR_C2_LS_HI:`RCR_C2_LS_LO] = ls_q;
                    rdata_d[`RCR_C2_HS_HI:`RCR_C2_HS_LO] = hs_q;
                end
                `RCR_ADDR_ANALOG_MUX_CHANNEL:
                begin
                    rdata_d[`RCR_MX_RATIO] = ratio_q;
                    rdata_d[`RCR_MX_CH_HI:`RCR_MX_CH_LO] = chan_q;
                end
                default:
                    rdata_d = `RCR_ZERO16;
            endcase
        end
    end

    // ============================================================
    // analog settings bundle
    always_comb
    begin
        analog_d.boost_slew_sel = slew_d;
        analog_d.prereg_lowside_drive = ls_d;
        analog_d.prereg_highside_drive = hs_d;
        analog_d.analog_mux_channel_ratio = ratio_d;
        analog_d.analog_mux_channel = chan_d;
    end

    // output registers
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_rdata_q <= `RCR_ZERO16;
            o_rd_valid_q <= 1'b0;
            o_addr_err_q <= 1'b0;
            o_rail_en_q <= '0;
            o_prereg_pd_dis_q <= 1'b0;
            o_deep_failsafe_state_req_q <= 1'b0;
            o_ready_q <= 1'b0;
            o_analog_q <= '{2'h0, `RCR_LS_RESET, 2'h0, 1'b0, 5'h00};
        end
        else
        begin
            o_rdata_q <= rdata_d;
            o_rd_valid_q <= rd_valid_d;
            o_addr_err_q <= addr_err_d;
            o_rail_en_q <= rail_on; // follows the keepers by one edge
            o_prereg_pd_dis_q <= pd_dis_d;
            o_deep_failsafe_state_req_q <= deep_failsafe_state_d;
            o_ready_q <= running;
            o_analog_q <= analog_d;
        end
    end

endmodule // rcr_regulator_ctrl

/* tb/rcr_regulator_ctrl_sva.sv */
`include "rcr_defines.svh"

module rcr_regulator_ctrl_chk
    import rcr_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // register port
    input wire rcr_req_t i_req,
    input wire logic [15:0] o_rdata_q,
    input wire logic o_rd_valid_q,
    input wire logic o_addr_err_q,
    // configuration and thermal pins
    input wire rcr_otp_t i_otp,
    input wire logic [5:0] i_thermal_shutdown,
    // regulator controls
    input wire logic [6:0] o_rail_en_q,
    input wire logic o_prereg_pd_dis_q,
    input wire logic o_deep_failsafe_state_req_q,
    input wire logic o_ready_q,
    input wire rcr_analog_t o_analog_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // write takes per register
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic w1;
    logic w2;
    logic wm;
    assign w1 = i_req.wr && o_ready_q && i_req.addr == `RCR_ADDR_CTRL1;
    assign w2 = i_req.wr && o_ready_q && i_req.addr == `RCR_ADDR_CTRL2;
    assign wm = i_req.wr && o_ready_q && i_req.addr == `RCR_ADDR_ANALOG_MUX_CHANNEL;

    property p_off;
        w1 |-> ##2 (o_rail_en_q & $past(i_req.wdata[14:8], 2)) == 7'h00;
    endproperty
    a_off: assert property (p_off) else $error("rail stayed on");
    property p_on;
        w1 && i_req.wdata[14:8] == 7'h00 && i_thermal_shutdown == 6'h00 |-> ##2
            (o_rail_en_q & $past(i_req.wdata[6:0], 2)) == $past(i_req.wdata[6:0], 2);
    endproperty
    a_on: assert property (p_on) else $error("not on");
    property p_zero;
        w1 && i_req.wdata[14:0] == 15'h0000 && i_thermal_shutdown == 6'h00 |-> ##2
            o_rail_en_q == $past(o_rail_en_q);
    endproperty
    a_zero: assert property (p_zero) else $error("zero write moved a rail");
    property p_cfg;
        w2 |=> o_analog_q.boost_slew_sel == $past(i_req.wdata[15:14])
            && o_analog_q.prereg_lowside_drive == $past(i_req.wdata[4:3])
            && o_analog_q.prereg_highside_drive == $past(i_req.wdata[1:0]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("cfg wrong");
    property p_mux;
        wm |=> {o_analog_q.analog_mux_channel_ratio, o_analog_q.analog_mux_channel}
            == $past(i_req.wdata[5:0]);
    endproperty
    a_mux: assert property (p_mux) else $error("mux select wrong");
    property p_deep;
        o_deep_failsafe_state_req_q |-> $past(i_thermal_shutdown, 3) != 6'h00;
    endproperty
    a_deep: assert property (p_deep) else $error("failsafe without trip");
    property p_por;
        $fell(i_rst) |-> ##2 !o_ready_q ##1 o_ready_q && o_rail_en_q == i_otp.rail_en
            && o_analog_q.prereg_highside_drive == i_otp.hs_drive
            && o_analog_q.boost_slew_sel == i_otp.boost_slew
            && o_analog_q.prereg_lowside_drive == 2'h3;
    endproperty
    a_por: assert property (p_por) else $error("power-up load wrong");
    property p_rd1;
        i_req.rd && i_req.addr == `RCR_ADDR_CTRL1 |=> o_rd_valid_q && o_rdata_q[14:0] == 15'h0000;
    endproperty
    a_rd1: assert property (p_rd1) else $error("request bits read back");
    property p_rdm;
        i_req.rd && !i_req.wr && i_req.addr == `RCR_ADDR_ANALOG_MUX_CHANNEL |=> o_rdata_q ==
            {10'h000, $past(o_analog_q.analog_mux_channel_ratio), $past(o_analog_q.analog_mux_channel)};
    endproperty
    a_rdm: assert property (p_rdm) else $error("mux readback wrong");
    c_w1: cover property (w1);
    c_deep: cover property (o_deep_failsafe_state_req_q);
    c_err: cover property (o_addr_err_q);
endmodule // rcr_regulator_ctrl_chk

/* tb/rcr_regulator_ctrl_test.sv */
`include "rcr_defines.svh"

module rcr_regulator_ctrl_test
    import rcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // design signals and bench state
    logic i_sys_clk;
    logic i_rst;
    rcr_req_t i_req;
    rcr_otp_t i_otp;
    logic [5:0] i_thermal_shutdown;
    logic [15:0] o_rdata_q;
    logic o_rd_valid_q, o_addr_err_q, o_prereg_pd_dis_q, o_deep_failsafe_state_req_q, o_ready_q;
    logic [6:0] o_rail_en_q;
    rcr_analog_t o_analog_q;
    int miscompares = 0;
    int compares = 0;
    int n;
    logic [15:0] seed = 16'h0037;
    logic [15:0] w;
    logic [15:0] rd_q;
    logic [6:0] exp_rail;

    rcr_regulator_ctrl rcr_regulator_ctrl_inst (.i_sys_clk, .i_rst, .i_req, .o_rdata_q,
        .o_rd_valid_q, .o_addr_err_q, .i_otp, .i_thermal_shutdown, .o_rail_en_q,
        .o_prereg_pd_dis_q, .o_deep_failsafe_state_req_q, .o_ready_q, .o_analog_q);

    // 100 MHz clock
    initial
    begin
        i_sys_clk = 1'h0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one-cycle write and read strobes
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        i_req <= '{1'h1, 1'h0, a, d};
        @(posedge i_sys_clk);
        i_req.wr <= 1'h0;
    endtask

    task automatic rd(input logic [5:0] a);
        @(posedge i_sys_clk);
        i_req <= '{1'h0, 1'h1, a, 16'h0000};
        @(posedge i_sys_clk);
        i_req.rd <= 1'h0;
        #1 chk({15'h0000, o_rd_valid_q}, 16'h0001);
        rd_q = o_rdata_q;
    endtask

    // request write with rail model
    task automatic wr1(input logic [15:0] d);
        wr(`RCR_ADDR_CTRL1, d);
        exp_rail = (exp_rail | d[6:0]) & ~d[14:8];
        @(posedge i_sys_clk);
        #1 chk({9'h000, o_rail_en_q}, {9'h000, exp_rail});
        chk({15'h0000, o_prereg_pd_dis_q}, {15'h0000, d[15]});
    endtask

    // reset with random configuration, then check the load
    task automatic boot();
        seed = lfsr(seed);
        @(posedge i_sys_clk);
        i_rst <= 1'h1;
        i_otp <= {seed, seed[15]};
        repeat (10) @(posedge i_sys_clk);
        i_rst <= 1'h0;
        n = 0;
        while (o_ready_q !== 1'h1 && n < 20)
        begin
            @(posedge i_sys_clk);
            #1 n++;
        end
        chk({15'h0000, o_ready_q}, 16'h0001);
        if (o_ready_q !== 1'h1)
            end_of_test();
        exp_rail = i_otp.rail_en;
        chk({9'h000, o_rail_en_q}, {9'h000, exp_rail});
        rd(`RCR_ADDR_CTRL2);
        chk(rd_q, {i_otp.boost_slew, i_otp.thermal_reaction, 6'h06, i_otp.hs_drive});
    endtask

    // main sequence
    initial
    begin
        i_rst = 1'h1;
        i_req = '0;
        i_otp = '0;
        i_thermal_shutdown = 6'h00;
        boot();
        for (int i = 0; i < 7; i++)
        begin
            wr1(16'h0100 << i);
            wr1(16'h0000);
            wr1(16'h0001 << i);
        end
        repeat (40)
        begin
            seed = lfsr(seed);
            wr1(seed & 16'hFF7F);
        end
        // pull-down disable alone, then request bits must read back as zero
        wr1(16'h8000);
        rd(`RCR_ADDR_CTRL1);
        chk(rd_q, 16'h8000);
        // write to an unmapped address flags an error
        wr(6'h3F, 16'hFFFF);
        #1 chk({15'h0000, o_addr_err_q}, 16'h0001);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            w = {2'(i), seed[5:0], 3'h0, 2'(i + 1), 1'h0, 2'(i + 3)};
            wr(`RCR_ADDR_CTRL2, w);
            #1 chk({10'h000, o_analog_q.boost_slew_sel, o_analog_q.prereg_lowside_drive,
                o_analog_q.prereg_highside_drive},
                {10'h000, w[15:14], w[4:3], w[1:0]});
            rd(`RCR_ADDR_CTRL2);
            chk(rd_q, w);
            w = {10'h000, i[0], seed[10:6]};
            wr(`RCR_ADDR_ANALOG_MUX_CHANNEL, w);
            #1 chk({10'h000, o_analog_q.analog_mux_channel_ratio, o_analog_q.analog_mux_channel}, w);
            rd(`RCR_ADDR_ANALOG_MUX_CHANNEL);
            chk(rd_q, w);
        end
        rd(6'h3F);
        chk({o_addr_err_q, rd_q[14:0]}, 16'h8000);
        // trip each thermal pin with alternating reactions
        wr(`RCR_ADDR_CTRL2, 16'h2A00);
        for (int i = 0; i < 6; i++)
        begin
            wr1(16'h007F);
            i_thermal_shutdown <= 6'h01 << i;
            n = 0;
            repeat (8)
            begin
                @(posedge i_sys_clk);
                #1 n += o_deep_failsafe_state_req_q;
            end
            chk(n[15:0], 16'((6'h2A >> i) & 6'h01));
            exp_rail[i] = 1'h0;
            chk({9'h000, o_rail_en_q}, {9'h000, exp_rail});
            @(posedge i_sys_clk);
            i_thermal_shutdown <= 6'h00;
            repeat (4) @(posedge i_sys_clk);
        end
        boot();
        end_of_test();
    end
endmodule // rcr_regulator_ctrl_test

bind rcr_regulator_ctrl rcr_regulator_ctrl_chk rcr_regulator_ctrl_chk_inst (.i_sys_clk, .i_rst,
    .i_req, .o_rdata_q, .o_rd_valid_q, .o_addr_err_q, .i_otp, .i_thermal_shutdown,
    .o_rail_en_q, .o_prereg_pd_dis_q, .o_deep_failsafe_state_req_q, .o_ready_q, .o_analog_q);
